// ===== design/edge_if.sv
`timescale 1ns/10ps
interface edge_if;
    logic rise;
    logic fall;
    modport det (output rise, output fall);
    modport use_side (input rise, input fall);
endinterface : edge_if

// ===== design/pin_edge.sv
`timescale 1ns/10ps
module pin_edge (
    input  wire logic mclk,
    input  wire logic arst_n,
    input  wire logic din,
    edge_if.det       ev
);
    logic din_reg;

    // =========================================================
    // Previous level of the pin
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            din_reg <= 1'b0;
        end else begin
            din_reg <= din;
        end
    end

    assign ev.rise = din & ~din_reg;
    assign ev.fall = ~din & din_reg;
endmodule : pin_edge

// ===== design/std_timer.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Period compare_p_value times 256, zero gives 65536
// - Duty at or over period gives full
// - Swap: period from compare_a_value, duty compare_p_value*256
// - Clear starts period; forced levels keep running
// - Clear source select ignored in PWM
// - Counter-on rise starts counter and pulse
// - Single pulse external clock pin edge sets counter-on
// - Compare A match or software ends pulse
// - Single pulse compare A raises request
// - Single pulse counter zeroes only on start
// - Capture mode 01, started by counter-on rise
// - Active capture edge copies counter, raises request
// - Capture counter runs until counter-on falls
// - Capture compare P clears counter, raises request
// - Pin function 11 disables capture only
// - Capture mode has no output function
// - Compare P matches compare_p_value - 1 in the upper byte with the low byte all ones
// - Initial level picks sense, invert flips pin
module std_timer
    import tmr_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              arst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              external_timer_clock_pin,
    input  wire logic              capture_input_pin,
    output logic                   timer_output_pin,
    output logic                   timer_output_pin_oe,
    output logic                   irq_cmp_a,
    output logic                   irq_cmp_p
);
    // =========================================================
    // Registers
    logic [2:0]  cks_reg;
    logic        counter_on_bit;
    logic        on_next;
    logic        on_rise;
    mode_t       mode_reg;
    logic [1:0]  pin_function_field;
    logic        output_initial_level;
    logic        output_invert;
    logic        period_duty_swap;
    logic        clear_source_select;
    logic [15:0] cnt_reg;
    logic [15:0] compare_a_value;
    logic [7:0]  compare_p_value;
    logic [5:0]  pre_reg;
    logic [31:0] prdata_reg;
    logic        out_reg;
    logic        oe_reg;
    logic        irq_a_reg;
    logic        irq_p_reg;

    edge_if ck_ev ();
    edge_if cap_ev ();

    pin_edge u_ck_edge (
        .mclk   (mclk),
        .arst_n (arst_n),
        .din    (external_timer_clock_pin),
        .ev     (ck_ev.det)
    );

    pin_edge u_cap_edge (
        .mclk   (mclk),
        .arst_n (arst_n),
        .din    (capture_input_pin),
        .ev     (cap_ev.det)
    );

    // =========================================================
    // APB slave
    logic wr_acc;
    logic rd_setup;
    logic mapped;
    logic [31:0] rd_mux;

    assign wr_acc   = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign mapped   = (paddr == OFF_CTRL0) || (paddr == OFF_CTRL1) ||
                      (paddr == OFF_COUNT) || (paddr == OFF_CMPA) ||
                      (paddr == OFF_CMPP) || (paddr == OFF_STATUS);
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mapped;
    assign prdata   = prdata_reg;

    always_comb begin
        rd_mux = '0;
        unique case (paddr)
            OFF_CTRL0: begin
                rd_mux[CKS_LSB +: 3] = cks_reg;
                rd_mux[ON_BIT]       = counter_on_bit;
            end
            OFF_CTRL1: begin
                rd_mux[MODE_LSB +: 2] = mode_reg;
                rd_mux[FN_LSB +: 2]   = pin_function_field;
                rd_mux[OC_BIT]        = output_initial_level;
                rd_mux[POL_BIT]       = output_invert;
                rd_mux[SWAP_BIT]      = period_duty_swap;
                rd_mux[CLR_BIT]       = clear_source_select;
            end
            OFF_COUNT:  rd_mux[15:0] = cnt_reg;
            OFF_CMPA:   rd_mux[15:0] = compare_a_value;
            OFF_CMPP:   rd_mux[7:0]  = compare_p_value;
            OFF_STATUS: begin
                rd_mux[ST_PIN] = out_reg;
                rd_mux[ST_ON]  = counter_on_bit;
            end
            default:    rd_mux = '0;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_reg <= '0;
        end else if (rd_setup) begin
            prdata_reg <= rd_mux;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cks_reg              <= CKS_RST;
            mode_reg             <= MODE_CMP;
            pin_function_field   <= CTRL_RST[FN_LSB +: 2];
            output_initial_level <= CTRL_RST[OC_BIT];
            output_invert        <= CTRL_RST[POL_BIT];
            period_duty_swap     <= CTRL_RST[SWAP_BIT];
            clear_source_select  <= CTRL_RST[CLR_BIT];
            compare_p_value      <= CMPP_RST;
        end else if (wr_acc) begin
            if (paddr == OFF_CTRL0) begin
                cks_reg <= pwdata[CKS_LSB +: 3];
            end
            if (paddr == OFF_CTRL1) begin
                mode_reg             <= mode_t'(pwdata[MODE_LSB +: 2]);
                pin_function_field   <= pwdata[FN_LSB +: 2];
                output_initial_level <= pwdata[OC_BIT];
                output_invert        <= pwdata[POL_BIT];
                period_duty_swap     <= pwdata[SWAP_BIT];
                clear_source_select  <= pwdata[CLR_BIT];
            end
            if (paddr == OFF_CMPP) begin
                compare_p_value <= pwdata[7:0];
            end
        end
    end

    // =========================================================
    // Timer clock enable
    logic tick;
    logic ext_edge;

    assign ext_edge = (cks_reg == CKS_EXT_F) ? ck_ev.fall : ck_ev.rise;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pre_reg <= '0;
        end else begin
            pre_reg <= pre_reg + 6'h01;
        end
    end

    always_comb begin
        unique case (cks_reg)
            CKS_DIV4:  tick = (pre_reg & PRE_M4) == PRE_M4;
            CKS_DIV1:  tick = 1'b1;
            CKS_DIV16: tick = (pre_reg & PRE_M16) == PRE_M16;
            CKS_EXT_R: tick = ck_ev.rise;
            CKS_EXT_F: tick = ck_ev.fall;
            default:   tick = pre_reg == PRE_M64;
        endcase
    end

    // =========================================================
    // Comparators
    logic        is_pwm;
    logic        is_sp;
    logic        is_cap;
    logic        p_last;
    logic        a_last;
    logic [16:0] p_span;
    logic        a_hit;
    logic        p_hit;
    logic        cnt_clear;

    assign is_pwm = (mode_reg == MODE_PWM) && (pin_function_field != FN_SP);
    assign is_sp  = (mode_reg == MODE_PWM) &&
                    (pin_function_field == FN_SP);
    assign is_cap = mode_reg == MODE_CAP;
    // Compare P matches upper byte compare_p_value - 1 with the low byte all ones
    assign p_last = cnt_reg == {compare_p_value - P_ONE, LOW_ALL1};
    assign p_span = (compare_p_value == CMPP_ZERO) ? SPAN_MAX :
                    {1'b0, compare_p_value, LOW_ZERO};
    assign a_last = cnt_reg == compare_a_value - CNT_ONE;
    assign a_hit  = counter_on_bit & tick & a_last;
    assign p_hit  = counter_on_bit & tick & p_last;

    always_comb begin
        if (is_pwm) begin
            cnt_clear = period_duty_swap ? a_last : p_last;
        end else if (is_sp) begin
            cnt_clear = 1'b0;
        end else if (is_cap) begin
            cnt_clear = p_last;
        end else begin
            cnt_clear = clear_source_select ? a_last : p_last;
        end
    end

    // =========================================================
    // Counter-on bit
    always_comb begin
        on_next = counter_on_bit;
        if (wr_acc && paddr == OFF_CTRL0) begin
            on_next = pwdata[ON_BIT];
        end
        if (is_sp && ext_edge && !counter_on_bit) begin
            on_next = 1'b1;
        end
        if (is_sp && a_hit) begin
            on_next = 1'b0;
        end
    end

    assign on_rise = on_next & ~counter_on_bit;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            counter_on_bit <= CTRL_RST[ON_BIT];
        end else begin
            counter_on_bit <= on_next;
        end
    end

    // =========================================================
    // Counter
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= CNT_ZERO;
        end else if (on_rise) begin
            cnt_reg <= CNT_ZERO;
        end else if (counter_on_bit && tick) begin
            // Runs on whatever the capture pin does
            cnt_reg <= cnt_clear ? CNT_ZERO :
                       cnt_reg + CNT_ONE;
        end
    end

    // =========================================================
    // Capture
    logic cap_fire;
    logic cap_sel;

    always_comb begin
        unique case (pin_function_field)
            FN_RISE: cap_sel = cap_ev.rise;
            FN_FALL: cap_sel = cap_ev.fall;
            FN_BOTH: cap_sel = cap_ev.rise | cap_ev.fall;
            FN_NOCAP: cap_sel = 1'b0;
        endcase
    end

    assign cap_fire = cap_sel & is_cap & counter_on_bit;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            compare_a_value <= CMPA_RST;
        end else if (cap_fire) begin
            compare_a_value <= cnt_reg;
        end else if (wr_acc && paddr == OFF_CMPA) begin
            compare_a_value <= pwdata[15:0];
        end
    end

    // =========================================================
    // Compare requests
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_a_reg <= 1'b0;
            irq_p_reg <= 1'b0;
        end else begin
            irq_a_reg <= is_cap ? cap_fire : a_hit;
            irq_p_reg <= p_hit & ~is_sp;
        end
    end

    assign irq_cmp_a = irq_a_reg;
    assign irq_cmp_p = irq_p_reg;

    // =========================================================
    // Output pin
    logic duty_act;
    logic act;
    logic act_lvl;

    always_comb begin
        if (period_duty_swap) begin
            duty_act = {1'b0, cnt_reg} < p_span;
        end else begin
            duty_act = (cnt_reg < compare_a_value) ||
                       ({1'b0, compare_a_value} >= p_span);
        end
        unique case (pin_function_field)
            FN_INACT: act = 1'b0;
            FN_ACT:   act = 1'b1;
            FN_PWM:   act = duty_act;
            FN_SP:    act = counter_on_bit;
        endcase
    end

    assign act_lvl = output_initial_level ^ output_invert;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            out_reg <= 1'b0;
            oe_reg  <= 1'b0;
        end else if (mode_reg == MODE_PWM) begin
            out_reg <= act ? act_lvl : ~act_lvl;
            oe_reg  <= 1'b1;
        end else begin
            out_reg <= 1'b0;
            oe_reg  <= 1'b0;
        end
    end

    assign timer_output_pin    = out_reg;
    assign timer_output_pin_oe = oe_reg;

    // =========================================================
    // Assertions
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    logic full_duty;
    assign full_duty = is_pwm && !period_duty_swap &&
                       pin_function_field == FN_PWM &&
                       {1'b0, compare_a_value} >= p_span;

    a_pwm_full_duty: assert property (
        full_duty |=> timer_output_pin == $past(act_lvl))
        else $error("full duty not held");

    a_pwm_p_clear: assert property (
        is_pwm && !period_duty_swap && p_hit && !on_rise
        |=> cnt_reg == CNT_ZERO)
        else $error("pwm period clear missed");

    a_swap_a_clear: assert property (
        is_pwm && period_duty_swap && a_hit && !on_rise
        |=> cnt_reg == CNT_ZERO)
        else $error("swapped period clear missed");

    a_forced_active: assert property (
        mode_reg == MODE_PWM && pin_function_field == FN_ACT
        |=> timer_output_pin == $past(act_lvl) && timer_output_pin_oe)
        else $error("forced level wrong");

    a_sp_start: assert property (
        $rose(counter_on_bit) |-> cnt_reg == CNT_ZERO)
        else $error("counter not zeroed on start");

    a_sp_ext_set: assert property (
        is_sp && ext_edge && !counter_on_bit && !a_hit
        |=> counter_on_bit)
        else $error("pin edge did not start pulse");

    a_sp_a_end: assert property (
        is_sp && a_hit |=> !counter_on_bit && irq_cmp_a)
        else $error("compare A did not end pulse");

    a_cap_latch: assert property (
        cap_fire |=> compare_a_value == $past(cnt_reg) && irq_cmp_a)
        else $error("capture not latched");

    a_cap_off: assert property (
        is_cap && pin_function_field == FN_NOCAP
        |=> !irq_cmp_a)
        else $error("capture while disabled");

    a_cap_p_wrap: assert property (
        is_cap && p_hit && !on_rise
        |=> cnt_reg == CNT_ZERO && irq_cmp_p)
        else $error("capture wrap missed");

    a_cap_no_out: assert property (
        is_cap ##1 is_cap |-> !timer_output_pin_oe)
        else $error("output driven in capture");

    c_pwm_wrap: cover property (is_pwm && p_hit);
    c_sp_pulse: cover property (is_sp && a_hit);
    c_cap_event: cover property (cap_fire);
    c_ext_trig: cover property (is_sp && ext_edge && !counter_on_bit);
endmodule : std_timer

// ===== design/tmr_pkg.sv
package tmr_pkg;
    // =========================================================
    // Register map
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  OFF_CTRL0  = 8'h00;
    localparam logic [7:0]  OFF_CTRL1  = 8'h04;
    localparam logic [7:0]  OFF_COUNT  = 8'h08;
    localparam logic [7:0]  OFF_CMPA   = 8'h0c;
    localparam logic [7:0]  OFF_CMPP   = 8'h10;
    localparam logic [7:0]  OFF_STATUS = 8'h14;

    // =========================================================
    // Field positions
    localparam int ON_BIT   = 3;
    localparam int CKS_LSB  = 4;
    localparam int MODE_LSB = 6;
    localparam int FN_LSB   = 4;
    localparam int OC_BIT   = 3;
    localparam int POL_BIT  = 2;
    localparam int SWAP_BIT = 1;
    localparam int CLR_BIT  = 0;
    localparam int ST_PIN   = 0;
    localparam int ST_ON    = 1;

    // =========================================================
    // Reset values
    localparam logic [2:0]  CKS_RST  = 3'h0;
    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [15:0] CMPA_RST = 16'h0000;
    localparam logic [7:0]  CMPP_RST = 8'h00;

    // =========================================================
    // Modes and pin functions
    typedef enum logic [1:0] {
        MODE_CMP = 2'h0,
        MODE_CAP = 2'h1,
        MODE_PWM = 2'h2,
        MODE_TMR = 2'h3
    } mode_t;

    localparam logic [1:0] FN_INACT = 2'h0;
    localparam logic [1:0] FN_ACT   = 2'h1;
    localparam logic [1:0] FN_PWM   = 2'h2;
    localparam logic [1:0] FN_SP    = 2'h3;
    localparam logic [1:0] FN_RISE  = 2'h0;
    localparam logic [1:0] FN_FALL  = 2'h1;
    localparam logic [1:0] FN_BOTH  = 2'h2;
    localparam logic [1:0] FN_NOCAP = 2'h3;

    // =========================================================
    // Timer clock selection
    localparam logic [2:0] CKS_DIV4  = 3'h0;
    localparam logic [2:0] CKS_DIV1  = 3'h1;
    localparam logic [2:0] CKS_DIV16 = 3'h2;
    localparam logic [2:0] CKS_DIV64 = 3'h3;
    localparam logic [2:0] CKS_EXT_R = 3'h6;
    localparam logic [2:0] CKS_EXT_F = 3'h7;
    localparam logic [5:0] PRE_M4    = 6'h03;
    localparam logic [5:0] PRE_M16   = 6'h0f;
    localparam logic [5:0] PRE_M64   = 6'h3f;

    // =========================================================
    // Counter constants
    localparam logic [7:0]  LOW_ALL1   = 8'hff;
    localparam logic [7:0]  LOW_ZERO   = 8'h00;
    localparam logic [7:0]  P_ONE      = 8'h01;
    localparam logic [15:0] CNT_ONE    = 16'h0001;
    localparam logic [15:0] CNT_ZERO   = 16'h0000;
    localparam logic [16:0] SPAN_MAX   = 17'h10000;
    localparam logic [7:0]  CMPP_ZERO  = 8'h00;
endpackage : tmr_pkg

// ===== tb/pin_load.sv
`timescale 1ns/10ps
// =========================================================
// Source and load on the timer pins
module pin_load (
    input  wire logic mclk,
    input  wire logic timer_output_pin,
    input  wire logic timer_output_pin_oe,
    output logic      external_timer_clock_pin,
    output logic      capture_input_pin
);
    int hi_cnt = 0;

    initial begin
        external_timer_clock_pin = 1'b0;
        capture_input_pin = 1'b0;
    end

    // Load counts cycles driven high
    always @(posedge mclk) begin
        if (timer_output_pin_oe === 1'b1 && timer_output_pin === 1'b1) begin
            hi_cnt <= hi_cnt + 1;
        end
    end

    task drive_cap(input logic v);
        @(posedge mclk);
        capture_input_pin <= v;
    endtask : drive_cap

    // Rising edge on clock pin
    task kick();
        @(posedge mclk);
        external_timer_clock_pin <= 1'b1;
        repeat (2) @(posedge mclk);
        external_timer_clock_pin <= 1'b0;
    endtask : kick
endmodule : pin_load

// ===== tb/tb_std_timer.sv
`timescale 1ns/10ps
module tb_std_timer;
    import tmr_pkg::*;
    logic              mclk = 1'b0;
    logic              arst_n = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0]       pwdata = '0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              ext_pin;
    logic              cap_pin;
    logic              out_pin;
    logic              out_oe;
    logic              irq_a;
    logic              irq_p;
    logic [31:0]       seed = 32'd78570;
    logic [31:0]       rd;
    logic [31:0]       lo;
    logic [31:0]       hi;
    logic              err_seen;
    int                errors = 0;
    int                check_count = 0;
    int                cyc = 0;
    int                na = 0;
    int                np = 0;
    int                w;
    int                h;
    int                a0;
    int                p;

    std_timer i_dut (.mclk(mclk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_timer_clock_pin(ext_pin),
        .capture_input_pin(cap_pin), .timer_output_pin(out_pin),
        .timer_output_pin_oe(out_oe), .irq_cmp_a(irq_a),
        .irq_cmp_p(irq_p));

    pin_load i_pins (.mclk(mclk), .timer_output_pin(out_pin),
        .timer_output_pin_oe(out_oe), .external_timer_clock_pin(ext_pin),
        .capture_input_pin(cap_pin));

    // =========================================================
    // Clock, pulse counters, timeout
    always #20 mclk = ~mclk;

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        na <= na + int'(irq_a === 1'b1);
        np <= np + int'(irq_p === 1'b1);
        if (cyc == 60000) begin
            errors++;
            complete_run();
        end
    end

    // =========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [31:0] c1(int m, int f, int oc, int pol,
                                       int sw, int clr);
        return 32'(m * 64 + f * 16 + oc * 8 + pol * 4 + sw * 2 + clr);
    endfunction : c1

    task check(input string nm, input logic [31:0] seen,
               input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task run_pwm(input int ctl, input int a, input int pp, input int per,
                 input int eh, input int sw);
        int hh;
        int pa;
        apb(1'b1, OFF_CTRL0, 32'h10);
        apb(1'b1, OFF_CMPA, 32'(a));
        apb(1'b1, OFF_CMPP, 32'(pp));
        apb(1'b1, OFF_CTRL1, 32'(ctl));
        apb(1'b1, OFF_CTRL0, 32'h18);
        repeat (per + 40) @(posedge mclk);
        hh = i_pins.hi_cnt;
        pa = (sw != 0) ? na : np;
        repeat (per) @(posedge mclk);
        check("pwm_high", 32'(i_pins.hi_cnt - hh), 32'(eh));
        check("pwm_clear", 32'(((sw != 0) ? na : np) - pa), 32'h1);
    endtask : run_pwm

    task complete_run();
        if (errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    // =========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        apb(1'b0, OFF_CTRL1, 32'h0);
        check("ctrl1_rst", rd, 32'(CTRL_RST));
        apb(1'b0, OFF_CMPA, 32'h0);
        check("cmpa_rst", rd, 32'(CMPA_RST));
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped_err", {31'h0, err_seen}, 32'h1);
        check("oe_idle", {31'h0, out_oe}, 32'h0);
        for (int i = 0; i < 6; i++) begin
            w = (i == 5) ? 300 : int'(rnd() % 255) + 1;
            run_pwm(c1(2, 2, i % 2, (i / 2) % 2, 0, int'(rnd() % 2)), w, 1,
                    256, ((i % 2) != ((i / 2) % 2)) ? ((w > 256) ? 256 : w)
                    : 256 - w, 0);
        end
        run_pwm(c1(2, 2, 1, 0, 1, 0), 600, 1, 600, 256, 1);
        run_pwm(c1(2, 0, 1, 0, 0, 1), 100, 1, 256, 0, 0);
        run_pwm(c1(2, 1, 1, 0, 0, 0), 100, 1, 256, 256, 0);
        for (int k = 0; k < 2; k++) begin
            w = int'(rnd() % 90) + 10;
            apb(1'b1, OFF_CTRL0, 32'h10);
            apb(1'b1, OFF_CMPA, 32'(w));
            apb(1'b1, OFF_CTRL1, c1(2, 3, 1, 0, 1, 1));
            h = i_pins.hi_cnt;
            a0 = na;
            if (k == 0) begin
                apb(1'b1, OFF_CTRL0, 32'h18);
            end else begin
                i_pins.kick();
            end
            repeat (w + 20) @(posedge mclk);
            h = i_pins.hi_cnt - h;
            check("sp_width", 32'(h >= w - 1 && h <= w + 2), 32'h1);
            check("sp_irq", 32'(na - a0), 32'h1);
            apb(1'b0, OFF_STATUS, 32'h0);
            check("sp_on", {31'h0, rd[ST_ON]}, 32'h0);
        end
        apb(1'b1, OFF_CTRL0, 32'h10);
        apb(1'b1, OFF_CMPP, 32'h0);
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, OFF_CTRL1, c1(1, f, 1, 1, 1, 1));
            apb(1'b1, OFF_CMPA, 32'hbeef);
            i_pins.drive_cap(f == 1);
            apb(1'b1, OFF_CTRL0, 32'h18);
            repeat (int'(rnd() % 50) + 5) @(posedge mclk);
            apb(1'b0, OFF_COUNT, 32'h0);
            lo = rd;
            a0 = na;
            i_pins.drive_cap(f != 1);
            repeat (4) @(posedge mclk);
            i_pins.drive_cap(f == 1);
            repeat (4) @(posedge mclk);
            apb(1'b0, OFF_COUNT, 32'h0);
            hi = rd;
            check("cap_run", 32'(hi > lo), 32'h1);
            apb(1'b0, OFF_CMPA, 32'h0);
            check("cap_irq", 32'(na - a0),
                  (f == 2) ? 32'h2 : (f == 3) ? 32'h0 : 32'h1);
            check("cap_val", 32'((f == 3) ? (rd === 32'hbeef)
                  : (rd > lo && rd < hi)), 32'h1);
            check("cap_oe", {31'h0, out_oe}, 32'h0);
            apb(1'b1, OFF_CTRL0, 32'h10);
        end
        apb(1'b1, OFF_CMPP, 32'h1);
        apb(1'b1, OFF_CTRL0, 32'h18);
        repeat (20) @(posedge mclk);
        p = np;
        repeat (512) @(posedge mclk);
        check("cap_wrap", 32'(np - p), 32'h2);
        apb(1'b0, OFF_COUNT, 32'h0);
        check("cap_max", 32'(rd < 32'd256), 32'h1);
        complete_run();
    end
endmodule : tb_std_timer
